// [design/csr_core_regs.sv]
// Core special registers: math pair, stack pointer, code pointer, status and power control.
// Assumes the instruction logic on mclk drives direct reads/writes, bit ops, stack and ALU ops.
//
// Contract
// - Stack pointer increments before the pushed byte is written to RAM.
// - Stack pointer resets to 07H so first stacked byte lands at 08H.
// - Code pointer accessible as one 16-bit value or as two bytes.
// - Helper register is second operand and result for multiply and divide.
// - Main math register is primary operand and destination for arithmetic and logic.
// - Status word at D0H, resets to 00H, bit addressable.
// - Status bits: carry, half carry, user, bank select, overflow, user, parity.
// - Bank select bits choose the working bank as a plain binary number.
// - Power control at 87H, resets to 00H, not bit addressable.
// - Power control bits: baud double, wakes, reserved, spare flags, sleep, halt.
// - Reads of unoccupied addresses complete and return an unspecified value.
// - Addresses with low nibble 0H or 8H support single-bit access.
// - All core registers except program counter and banks live in register space.
// - A read-only register returns the silicon revision byte.
// - Lowest 32 RAM bytes are four banks of eight; bank select picks one.
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs
	import csr_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = SILICON_REV_ID
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  dir_addr,
	input  wire logic        dir_rd,
	input  wire logic        dir_wr,
	input  wire logic [7:0]  dir_wdata,
	output logic      [7:0]  dir_rdata,
	output logic             dir_rvalid,
	input  wire logic        bit_op,
	input  wire logic [2:0]  bit_sel,
	input  wire logic        bit_val,
	input  wire logic        push_req,
	input  wire logic        pop_req,
	output logic      [7:0]  stack_wr_addr,
	output logic             stack_wr_en,
	input  wire logic        ptr16_wr,
	input  wire logic [15:0] ptr16_wdata,
	input  wire logic        ptr16_inc,
	input  wire csr_alu_op_t alu_op,
	input  wire logic [7:0]  alu_operand,
	output logic      [7:0]  main_math_register,
	output logic      [7:0]  helper_register,
	output logic      [7:0]  stack_top_pointer,
	output logic      [15:0] code_address_pointer,
	output logic      [7:0]  cpu_status_word,
	output logic      [7:0]  power_control_word,
	output logic      [4:0]  bank_base_addr
);
	logic [7:0]  pointer_low_byte;
	logic [7:0]  pointer_high_byte;
	logic [7:0]  next_math;
	logic [7:0]  next_helper;
	logic [15:0] product;
	logic [8:0]  sum9;
	logic [4:0]  half9;
	logic        bit_capable;
	logic [7:0]  cur_byte;
	logic [7:0]  wr_value;
	logic        wr_hit;

	assign code_address_pointer = {pointer_high_byte, pointer_low_byte};
	assign product = main_math_register * helper_register;
	assign bit_capable = (dir_addr[3:0] == BIT_ADDR_LOW_0) ||
		(dir_addr[3:0] == BIT_ADDR_LOW_8);

	// Current contents at the direct address, also the base of a read-modify-write bit op
	always_comb begin
		case (dir_addr)
			ADDR_MATH_MAIN:   cur_byte = main_math_register;
			ADDR_MATH_HELPER: cur_byte = helper_register;
			ADDR_STACK_TOP:   cur_byte = stack_top_pointer;
			ADDR_PTR_LOW:     cur_byte = pointer_low_byte;
			ADDR_PTR_HIGH:    cur_byte = pointer_high_byte;
			ADDR_STATUS_WORD: cur_byte = cpu_status_word;
			ADDR_POWER_CTRL:  cur_byte = power_control_word;
			ADDR_SILICON_REV: cur_byte = REVISION_ID;
			default:          cur_byte = UNMAPPED_VALUE;
		endcase
	end

	// Bit ops only land on bit-capable addresses; the power word at 87H never qualifies
	always_comb begin
		wr_value = dir_wdata;
		wr_hit = dir_wr;
		if (bit_op) begin
			wr_value = cur_byte;
			wr_value[bit_sel] = bit_val;
			wr_hit = dir_wr && bit_capable;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dir_rdata <= ZERO_BYTE;
			dir_rvalid <= 1'b0;
		end else begin
			dir_rdata <= cur_byte;
			dir_rvalid <= dir_rd;
		end
	end

	// Stack: pointer moves first, RAM write address is the incremented value
	always_ff @(posedge mclk) begin
		if (rst) begin
			stack_top_pointer <= STACK_TOP_RESET;
			stack_wr_addr <= ZERO_BYTE;
			stack_wr_en <= 1'b0;
		end else begin
			stack_wr_en <= push_req;
			if (push_req) begin
				stack_top_pointer <= stack_top_pointer + 8'h01;
				stack_wr_addr <= stack_top_pointer + 8'h01;
			end else if (pop_req) begin
				stack_top_pointer <= stack_top_pointer - 8'h01;
			end else if (wr_hit && dir_addr == ADDR_STACK_TOP) begin
				stack_top_pointer <= wr_value;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pointer_low_byte <= ZERO_BYTE;
			pointer_high_byte <= ZERO_BYTE;
		end else if (ptr16_wr) begin
			{pointer_high_byte, pointer_low_byte} <= ptr16_wdata;
		end else if (ptr16_inc) begin
			{pointer_high_byte, pointer_low_byte} <= code_address_pointer + 16'h0001;
		end else if (wr_hit) begin
			if (dir_addr == ADDR_PTR_LOW)
				pointer_low_byte <= wr_value;
			if (dir_addr == ADDR_PTR_HIGH)
				pointer_high_byte <= wr_value;
		end
	end

	// Arithmetic: the main register is the destination, the helper takes the product high byte or the remainder
	always_comb begin
		next_math = main_math_register;
		next_helper = helper_register;
		sum9 = 9'h000;
		half9 = 5'h00;
		case (alu_op)
			CSR_ALU_ADD: begin
				sum9 = {1'b0, main_math_register} + {1'b0, alu_operand};
				half9 = {1'b0, main_math_register[3:0]} + {1'b0, alu_operand[3:0]};
				next_math = sum9[7:0];
			end
			CSR_ALU_SUB: begin
				sum9 = {1'b0, main_math_register} - {1'b0, alu_operand};
				half9 = {1'b0, main_math_register[3:0]} - {1'b0, alu_operand[3:0]};
				next_math = sum9[7:0];
			end
			CSR_ALU_MUL: begin
				next_math = product[7:0];
				next_helper = product[15:8];
			end
			CSR_ALU_DIV: begin
				if (helper_register != ZERO_BYTE) begin
					next_math = main_math_register / helper_register;
					next_helper = main_math_register % helper_register;
				end
			end
			CSR_ALU_ANL: next_math = main_math_register & alu_operand;
			CSR_ALU_ORL: next_math = main_math_register | alu_operand;
			default: begin
				if (wr_hit && dir_addr == ADDR_MATH_MAIN)
					next_math = wr_value;
				if (wr_hit && dir_addr == ADDR_MATH_HELPER)
					next_helper = wr_value;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			main_math_register <= ZERO_BYTE;
			helper_register <= ZERO_BYTE;
		end else begin
			main_math_register <= next_math;
			helper_register <= next_helper;
		end
	end

	// Flags from the ALU win over a software write in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_status_word <= STATUS_RESET;
		end else begin
			if (wr_hit && dir_addr == ADDR_STATUS_WORD)
				cpu_status_word[7:1] <= wr_value[7:1];
			case (alu_op)
				CSR_ALU_ADD, CSR_ALU_SUB: begin
					cpu_status_word[CARRY_BIT] <= sum9[8];
					cpu_status_word[HALF_CARRY_BIT] <= half9[4];
					cpu_status_word[RANGE_BIT] <= (alu_op == CSR_ALU_ADD) ?
						((main_math_register[7] == alu_operand[7]) &&
						 (sum9[7] != main_math_register[7])) :
						((main_math_register[7] != alu_operand[7]) &&
						 (sum9[7] != main_math_register[7]));
				end
				CSR_ALU_MUL: begin
					cpu_status_word[CARRY_BIT] <= 1'b0;
					cpu_status_word[RANGE_BIT] <= product[15:8] != ZERO_BYTE;
				end
				CSR_ALU_DIV: begin
					cpu_status_word[CARRY_BIT] <= 1'b0;
					cpu_status_word[RANGE_BIT] <= helper_register == ZERO_BYTE;
				end
				default: ;
			endcase
			// Parity is computed from the value the math register will hold
			cpu_status_word[PARITY_BIT] <= ^next_math;
		end
	end

	// Bank base address for working register access: bank number times eight
	always_ff @(posedge mclk) begin
		if (rst)
			bank_base_addr <= BANK_BASE_ZERO;
		else if (wr_hit && dir_addr == ADDR_STATUS_WORD)
			bank_base_addr <= {wr_value[BANK_HIGH_BIT:BANK_LOW_BIT], 3'b000};
		else
			bank_base_addr <= {cpu_status_word[BANK_HIGH_BIT:BANK_LOW_BIT], 3'b000};
	end

	// Power control: byte-wide writes only, reserved bit kept at zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			power_control_word <= POWER_CTRL_RESET;
		end else if (wr_hit && dir_addr == ADDR_POWER_CTRL) begin
			power_control_word <= wr_value;
			power_control_word[POWER_CONTROL_WORD_RSVD_BIT] <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [design/csr_pkg.sv]
// Package for the core special register block: addresses, reset values, field positions.
// Assumes an 8-bit direct address space shared with peripheral registers.
package csr_pkg;
	localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
	localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
	localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
	localparam logic [7:0] ADDR_POWER_CTRL  = 8'h87;
	localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
	localparam logic [7:0] ADDR_MATH_MAIN   = 8'he0;
	localparam logic [7:0] ADDR_MATH_HELPER = 8'hf0;
	localparam logic [7:0] ADDR_SILICON_REV = 8'hc2;
	localparam logic [7:0] STACK_TOP_RESET  = 8'h07;
	localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET     = 8'h00;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;
	localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;
	localparam logic [7:0] SILICON_REV_ID   = 8'h5a; // Arbitrary value
	localparam logic [3:0] BIT_ADDR_LOW_0   = 4'h0;
	localparam logic [3:0] BIT_ADDR_LOW_8   = 4'h8;
	localparam logic [4:0] BANK_BASE_ZERO   = 5'h00;
	localparam int CARRY_BIT      = 7;
	localparam int HALF_CARRY_BIT = 6;
	localparam int USER_ZERO_BIT  = 5;
	localparam int BANK_HIGH_BIT  = 4;
	localparam int BANK_LOW_BIT   = 3;
	localparam int RANGE_BIT      = 2;
	localparam int USER_ONE_BIT   = 1;
	localparam int PARITY_BIT     = 0;
	localparam int BAUD_DBL_BIT   = 7;
	localparam int SER_WAKE_BIT   = 6;
	localparam int IRQ0_WAKE_BIT  = 5;
	localparam int POWER_CONTROL_WORD_RSVD_BIT  = 4;
	localparam int SPARE1_BIT     = 3;
	localparam int SPARE0_BIT     = 2;
	localparam int SLEEP_BIT      = 1;
	localparam int HALT_BIT       = 0;
	typedef enum logic [2:0] {
		CSR_ALU_NONE, CSR_ALU_ADD, CSR_ALU_SUB, CSR_ALU_MUL, CSR_ALU_DIV, CSR_ALU_ANL, CSR_ALU_ORL
	} csr_alu_op_t;
endpackage

// [verif/csr_core_checker.sv]
// Timing checks on the core special register ports.
// Assumes one clock mclk and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module csr_core_checker
	import csr_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  dir_addr,
	input wire logic        dir_rd,
	input wire logic        dir_wr,
	input wire logic        bit_op,
	input wire logic        push_req,
	input wire logic        ptr16_wr,
	input wire logic [15:0] ptr16_wdata,
	input wire logic [7:0]  dir_rdata,
	input wire logic        dir_rvalid,
	input wire logic [7:0]  stack_wr_addr,
	input wire logic        stack_wr_en,
	input wire logic [7:0]  main_math_register,
	input wire logic [7:0]  stack_top_pointer,
	input wire logic [15:0] code_address_pointer,
	input wire logic [7:0]  cpu_status_word,
	input wire logic [7:0]  power_control_word,
	input wire logic [4:0]  bank_base_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rd_answered: assert property (dir_rd |=> dir_rvalid)
		else $error("read not answered");
	a_reset_values: assert property ($fell(rst) |-> stack_top_pointer == STACK_TOP_RESET
		&& cpu_status_word == STATUS_RESET && power_control_word == POWER_CTRL_RESET)
		else $error("bad reset value");
	a_push_first: assert property (push_req |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01
		&& stack_wr_en && stack_wr_addr == stack_top_pointer)
		else $error("push order wrong");
	a_ptr_load: assert property (ptr16_wr |=> code_address_pointer == $past(ptr16_wdata))
		else $error("pointer load wrong");
	a_status_read: assert property (dir_rd && dir_addr == ADDR_STATUS_WORD
		|=> dir_rdata == $past(cpu_status_word))
		else $error("status read wrong");
	a_power_no_bit: assert property (dir_wr && bit_op && dir_addr == ADDR_POWER_CTRL
		|=> $stable(power_control_word))
		else $error("power bit write taken");
	a_parity_even: assert property (cpu_status_word[PARITY_BIT] == ^main_math_register)
		else $error("parity wrong");
	a_bank_base: assert property ($stable(cpu_status_word)
		|-> bank_base_addr == {cpu_status_word[4:3], 3'b000})
		else $error("bank base wrong");
endmodule
`default_nettype wire

// [verif/csr_stack_ram.sv]
// Stack RAM model beside the core: records where pushed bytes land.
// Assumes stack writes are one-cycle strobes on mclk.
`timescale 1ns/1ps
`default_nettype none
module csr_stack_ram (
	input  wire logic       mclk,
	input  wire logic       stack_wr_en,
	input  wire logic [7:0] stack_wr_addr,
	output logic      [7:0] last_addr,
	output logic      [7:0] wr_count
);
	initial begin
		last_addr = 8'h00;
		wr_count = 8'h00;
	end
	// Address is taken only with the strobe, as a real RAM would
	always @(posedge mclk) begin
		if (stack_wr_en) begin
			last_addr <= stack_wr_addr;
			wr_count <= wr_count + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for csr_core_regs with the stack RAM model.
// Assumes csr_pkg is compiled first; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import csr_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, dir_rd = 1'b0, dir_wr = 1'b0, bit_op = 1'b0, bit_val = 1'b0;
	logic push_req = 1'b0, pop_req = 1'b0, ptr16_wr = 1'b0, ptr16_inc = 1'b0;
	logic [7:0] dir_addr = 8'h00, dir_wdata = 8'h00, alu_operand = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic [15:0] ptr16_wdata = 16'h0000;
	csr_alu_op_t alu_op = CSR_ALU_NONE;
	wire logic [7:0] dir_rdata, stack_wr_addr, main_math_register, helper_register;
	wire logic [7:0] stack_top_pointer, cpu_status_word, power_control_word, last_addr, wr_count;
	wire logic [15:0] code_address_pointer;
	wire logic [4:0] bank_base_addr;
	wire logic dir_rvalid, stack_wr_en;
	int checks = 0, fail_count = 0;
	csr_core_regs dut (.mclk, .rst, .dir_addr, .dir_rd, .dir_wr, .dir_wdata, .dir_rdata,
		.dir_rvalid, .bit_op, .bit_sel, .bit_val, .push_req, .pop_req, .stack_wr_addr,
		.stack_wr_en, .ptr16_wr, .ptr16_wdata, .ptr16_inc, .alu_op, .alu_operand,
		.main_math_register, .helper_register, .stack_top_pointer, .code_address_pointer,
		.cpu_status_word, .power_control_word, .bank_base_addr);
	csr_stack_ram u_ram (.mclk, .stack_wr_en, .stack_wr_addr, .last_addr, .wr_count);
	always #12.5 mclk = ~mclk;
	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
		@(negedge mclk);
		{dir_addr, dir_wdata, bit_op, dir_wr} = {a, d, b, 1'b1};
		@(negedge mclk);
		{bit_op, dir_wr} = 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		@(negedge mclk);
		{dir_addr, dir_rd} = {a, 1'b1};
		@(negedge mclk);
		dir_rd = 1'b0;
		for (n = 0; n < 4 && dir_rvalid !== 1'b1; n++) @(negedge mclk);
		if (n == 4) begin
			fail_count++;
			tally_and_finish();
		end
		chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, dir_rdata});
	endtask
	task automatic t_stack();
		@(negedge mclk);
		push_req = 1'b1;
		repeat (2) @(negedge mclk);
		push_req = 1'b0;
		@(negedge mclk);
		chk("ram count", 16'h0002, {8'h00, wr_count});
		chk("ram addr", 16'h0009, {8'h00, last_addr});
		pop_req = 1'b1;
		@(negedge mclk);
		pop_req = 1'b0;
		rd(ADDR_STACK_TOP, 8'h08);
	endtask
	task automatic t_ptr();
		@(negedge mclk);
		{ptr16_wdata, ptr16_wr} = {16'h12ff, 1'b1};
		@(negedge mclk);
		{ptr16_wr, ptr16_inc} = 2'b01;
		@(negedge mclk);
		ptr16_inc = 1'b0;
		chk("pointer", 16'h1300, code_address_pointer);
		wr(ADDR_PTR_HIGH, 8'h45);
		rd(ADDR_PTR_LOW, 8'h00);
		chk("pointer", 16'h4500, code_address_pointer);
	endtask
	task automatic t_regs();
		wr(ADDR_POWER_CTRL, 8'hff);
		rd(ADDR_POWER_CTRL, 8'hef);
		{bit_sel, bit_val} = 4'h0;
		wr(ADDR_POWER_CTRL, 8'h00, 1'b1);
		rd(ADDR_POWER_CTRL, 8'hef);
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_STATUS_WORD, 8'(b * 8));
			rd(ADDR_STATUS_WORD, 8'(b * 8));
			chk("bank base", 16'(b * 8), {11'h000, bank_base_addr});
		end
		{bit_sel, bit_val} = {3'h5, 1'b1};
		wr(ADDR_STATUS_WORD, 8'h00, 1'b1);
		rd(ADDR_STATUS_WORD, 8'h38);
		wr(ADDR_STATUS_WORD, 8'h01);
		rd(ADDR_STATUS_WORD, 8'h00);
	endtask
	task automatic t_alu();
		wr(ADDR_MATH_MAIN, 8'h20);
		wr(ADDR_MATH_HELPER, 8'h10);
		@(negedge mclk);
		alu_op = CSR_ALU_MUL;
		@(negedge mclk);
		alu_op = CSR_ALU_ADD;
		alu_operand = 8'h02;
		chk("helper", 16'h0002, {8'h00, helper_register});
		chk("flags", 16'h0004, {8'h00, cpu_status_word & 8'h84});
		@(negedge mclk);
		alu_op = CSR_ALU_NONE;
		rd(ADDR_MATH_MAIN, 8'h02);
		chk("parity", 16'h0001, {15'h0000, cpu_status_word[PARITY_BIT]});
	endtask
	// Divide, subtract with borrow, then the two logic ops, each held for one edge
	task automatic t_math();
		wr(ADDR_MATH_MAIN, 8'h35);
		wr(ADDR_MATH_HELPER, 8'h06);
		@(negedge mclk);
		alu_op = CSR_ALU_DIV;
		@(negedge mclk);
		chk("quotient", 16'h0008, {8'h00, main_math_register});
		chk("remainder", 16'h0005, {8'h00, helper_register});
		chk("div flags", 16'h0000, {8'h00, cpu_status_word & 8'h84});
		alu_op = CSR_ALU_SUB;
		alu_operand = 8'h09;
		@(negedge mclk);
		chk("difference", 16'h00ff, {8'h00, main_math_register});
		chk("sub flags", 16'h00c0, {8'h00, cpu_status_word});
		alu_op = CSR_ALU_ANL;
		alu_operand = 8'h3c;
		@(negedge mclk);
		chk("and result", 16'h003c, {8'h00, main_math_register});
		alu_op = CSR_ALU_ORL;
		alu_operand = 8'h41;
		@(negedge mclk);
		alu_op = CSR_ALU_NONE;
		rd(ADDR_MATH_MAIN, 8'h7d);
		chk("or flags", 16'h00c0, {8'h00, cpu_status_word});
	endtask
	// Second reset in mid-run after most registers have moved off their reset values; the bank base is still zero
	task automatic t_reset();
		@(negedge mclk);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		rd(ADDR_STACK_TOP, STACK_TOP_RESET);
		rd(ADDR_POWER_CTRL, POWER_CTRL_RESET);
		rd(ADDR_STATUS_WORD, STATUS_RESET);
		rd(ADDR_MATH_MAIN, ZERO_BYTE);
		chk("bank base", 16'h0000, {11'h000, bank_base_addr});
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		rd(ADDR_STACK_TOP, STACK_TOP_RESET);
		rd(ADDR_STATUS_WORD, STATUS_RESET);
		rd(ADDR_POWER_CTRL, POWER_CTRL_RESET);
		t_stack();
		t_ptr();
		t_regs();
		t_alu();
		t_math();
		t_reset();
		// Only unoccupied and revision places are probed, never reserved ones
		rd(8'h80, UNMAPPED_VALUE);
		wr(ADDR_SILICON_REV, 8'h00);
		rd(ADDR_SILICON_REV, SILICON_REV_ID);
		tally_and_finish();
	end
endmodule
bind csr_core_regs csr_core_checker u_chk (.mclk, .rst, .dir_addr, .dir_rd, .dir_wr, .bit_op,
	.push_req, .ptr16_wr, .ptr16_wdata, .dir_rdata, .dir_rvalid, .stack_wr_addr, .stack_wr_en,
	.main_math_register, .stack_top_pointer, .code_address_pointer, .cpu_status_word,
	.power_control_word, .bank_base_addr);
`default_nettype wire
